// >>> src/tac_serial_ctrl.sv
// serial command, conversion framing and power control of a resistive
// touch converter, plus the result fifo between analog core and serializer.
// assumes serial clock, chip select, data in and x+ sense are async pins;
// the analog core pushes one result word per conversion start.
`default_nettype none

// ************************************************************
// result fifo
// ************************************************************
module tac_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [CW-1:0] count;
  } tac_fifo_s;

  tac_fifo_s q, d;
  logic push, pop;

  assign in_ready = (q.count != FULL);
  assign out_valid = (q.count != '0);
  assign out_data = q.mem[q.rd];
  assign push = in_valid & in_ready;
  assign pop = out_ready & out_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = (q.wr == LAST) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
    end
    if (push && !pop) begin
      d.count = q.count + 1'b1;
    end else if (pop && !push) begin
      d.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '0;
    end else if (clk_en) begin
      q <= d;
    end
  end
endmodule

// ************************************************************
// serial control top
// ************************************************************
module tac_serial_ctrl #(
  // per {channel, reference mode bit}: switch set xp, xm, yp, ym
  parameter logic [15:0][3:0] DRV_MAP = 64'h0000_0000_0000_0000,
  // channels that measure x, y or z position; arbitrary default
  parameter logic [7:0] POS_CHAN_MASK = 8'h3a
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // serial pins to and from the host
  input wire logic serial_clock,
  input wire logic cs_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_oe,
  output logic busy,
  output logic busy_oe,
  // touch alert
  input wire logic xp_sense,
  output logic touch_alert_out,
  // analog core results
  input wire logic result_valid,
  output logic result_ready,
  input wire logic [tac_pkg::RES_W-1:0] result_data,
  // analog core controls
  output tac_pkg::tac_ana_s analog_ctrl
);

  typedef struct packed {
    logic sclk_m, sclk_s, sclk_p;
    logic cs_m, cs_s;
    logic din_m, din_s;
    logic xp_m, xp_s;
    logic active;
    logic [4:0] cnt;
    tac_pkg::tac_cmd_s cmd;
    logic acq;
    logic go;
    logic busy;
    logic conv;
    logic conv_start;
    logic [3:0] outcnt;
    logic [tac_pkg::RES_W-1:0] outsh;
    logic dout;
    logic ref_on;
    logic pen_en;
  } tac_state_s;

  tac_state_s q, d;
  logic rise, fall, pop, res_valid;
  logic [tac_pkg::RES_W-1:0] res_data;
  logic [4:0] spacing;
  logic [3:0] drv;

  // ************************************************************
  // result buffer
  // ************************************************************
  // the analog core stalls on result_ready when the serializer lags
  tac_fifo #(
    .WIDTH(tac_pkg::RES_W),
    .DEPTH(tac_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(res_valid),
    .out_ready(pop),
    .out_data(res_data)
  );

  // ************************************************************
  // next state
  // ************************************************************
  // edges only from synchronised copies; first stages feed nothing else
  assign rise = q.sclk_s & ~q.sclk_p;
  assign fall = ~q.sclk_s & q.sclk_p;
  assign spacing = q.cmd.mode_8bit ? tac_pkg::SPACING_8
                                   : tac_pkg::SPACING_12;
  assign pop = fall & q.go & ~q.cs_s & clk_en;

  always_comb begin
    d = q;
    d.conv_start = 1'b0;
    d.sclk_m = serial_clock;
    d.sclk_s = q.sclk_m;
    d.sclk_p = q.sclk_s;
    d.cs_m = cs_n;
    d.cs_s = q.cs_m;
    d.din_m = serial_in;
    d.din_s = q.din_m;
    d.xp_m = xp_sense;
    d.xp_s = q.xp_m;
    if (q.cs_s) begin
      // deselect drops the conversion but leaves the reference alone
      d.active = 1'b0;
      d.cnt = '0;
      d.acq = 1'b0;
      d.go = 1'b0;
      d.busy = 1'b0;
      d.conv = 1'b0;
      d.outcnt = '0;
      d.dout = 1'b0;
      d.pen_en = ~q.cmd.converter_powerdown_bit;
    end else begin
      if (rise) begin
        if (q.din_s && (!q.active || q.cnt >= spacing)) begin
          d.active = 1'b1;
          d.cnt = tac_pkg::CNT_START;
          d.pen_en = 1'b0;
        end else if (q.active && q.cnt != tac_pkg::CNT_MAX) begin
          d.cnt = q.cnt + 1'b1;
          if (d.cnt >= tac_pkg::CNT_CHAN_FIRST &&
              d.cnt <= tac_pkg::CNT_CHAN_LAST) begin
            d.cmd.channel_select_field =
              {q.cmd.channel_select_field[1:0], q.din_s};
          end
          case (d.cnt)
            tac_pkg::CNT_MODE: begin
              d.cmd.mode_8bit = q.din_s;
              d.acq = 1'b1;
            end
            tac_pkg::CNT_REF: begin
              d.cmd.reference_mode_bit = q.din_s;
            end
            tac_pkg::CNT_PD1: begin
              d.cmd.reference_power_bit = q.din_s;
            end
            tac_pkg::CNT_PD0: begin
              d.cmd.converter_powerdown_bit = q.din_s;
              d.go = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      if (fall) begin
        if (q.go) begin
          // hold the sample and start converting
          d.go = 1'b0;
          d.acq = 1'b0;
          d.busy = 1'b1;
          d.conv = 1'b1;
          d.conv_start = 1'b1;
          d.ref_on = q.cmd.reference_power_bit;
          d.outsh = '0;
          if (res_valid) begin
            // 8-bit results use the top of the word, msb first
            d.outsh = q.cmd.mode_8bit ? {res_data[11:4], 4'h0}
                                      : res_data;
          end
          d.outcnt = q.cmd.mode_8bit ? tac_pkg::BITS_8
                                     : tac_pkg::BITS_12;
          d.dout = 1'b0;
        end else if (q.outcnt != '0) begin
          d.busy = 1'b0;
          d.dout = q.outsh[tac_pkg::RES_W-1];
          d.outsh = {q.outsh[tac_pkg::RES_W-2:0], 1'b0};
          d.outcnt = q.outcnt - 1'b1;
          if (q.outcnt == 4'h1) begin
            // bit 1 has gone, so this falling edge ends the conversion
            d.conv = 1'b0;
            // an overlapped command has already disarmed detection and
            // owns the power bits now, so rearm only if none has started
            if (q.cnt > tac_pkg::CNT_PD0) begin
              d.pen_en = ~q.cmd.converter_powerdown_bit;
            end
          end
        end else begin
          d.dout = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      q <= '0;
      q.sclk_m <= 1'b0;
      q.cs_m <= 1'b1;
      q.cs_s <= 1'b1;
      q.cmd <= tac_pkg::CMD_RESET;
      q.ref_on <= tac_pkg::REF_ON_RESET;
      q.pen_en <= tac_pkg::PEN_EN_RESET;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ************************************************************
  // pins
  // ************************************************************
  assign serial_out = q.dout;
  assign serial_out_oe = ~q.cs_s;
  assign busy = q.busy;
  assign busy_oe = ~q.cs_s;

  // alert follows x+ while armed, otherwise parked by channel class
  always_comb begin
    if (q.pen_en) begin
      touch_alert_out = q.xp_s;
    end else if (POS_CHAN_MASK[q.cmd.channel_select_field]) begin
      touch_alert_out = 1'b0;
    end else begin
      touch_alert_out = 1'b1;
    end
  end

  // ************************************************************
  // analog controls
  // ************************************************************
  assign drv = DRV_MAP[{q.cmd.channel_select_field,
                        q.cmd.reference_mode_bit}];

  always_comb begin
    analog_ctrl.mux_sel = q.cmd.channel_select_field;
    analog_ctrl.ref_diff = ~q.cmd.reference_mode_bit;
    if (q.acq || (q.conv && !q.cmd.reference_mode_bit)) begin
      analog_ctrl.panel_drive = drv;
    end else if (q.pen_en) begin
      analog_ctrl.panel_drive = tac_pkg::DRV_Y_MINUS;
    end else begin
      analog_ctrl.panel_drive = '0;
    end
    analog_ctrl.sample_en = q.acq;
    // gated by select so a deselect drops hold in the cycle power goes
    analog_ctrl.hold_en = q.conv & ~q.cs_s;
    analog_ctrl.conv_start = q.conv_start & ~q.cs_s;
    // powers up with no wake delay and stays up while the clock pauses
    analog_ctrl.adc_power_on = ~q.cs_s &
      (q.cmd.converter_powerdown_bit | q.acq | q.go | q.conv);
    analog_ctrl.ref_power_on = q.ref_on;
    analog_ctrl.xp_pullup_en = q.pen_en;
  end

endmodule

`default_nettype wire

// >>> src/tac_pkg.sv
// package for the touch converter serial control block: bit positions,
// counts, reset values and the shared structs.
// assumes a single 125 MHz system clock and a host-driven serial clock pin.
`default_nettype none

package tac_pkg;

  // ************************************************************
  // command byte layout
  // ************************************************************
  localparam int CMD_W = 8;
  localparam logic [4:0] CNT_CHAN_FIRST = 5'h02;
  localparam logic [4:0] CNT_CHAN_LAST = 5'h04;
  localparam logic [4:0] CNT_MODE = 5'h05;
  localparam logic [4:0] CNT_REF = 5'h06;
  localparam logic [4:0] CNT_PD1 = 5'h07;
  localparam logic [4:0] CNT_PD0 = 5'h08;
  localparam logic [4:0] CNT_START = 5'h01;
  localparam logic [4:0] CNT_MAX = 5'h1f;

  // ************************************************************
  // conversion framing
  // ************************************************************
  localparam int RES_W = 12;
  localparam logic [3:0] BITS_12 = 4'hc;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [4:0] SPACING_12 = 5'h0f;
  localparam logic [4:0] SPACING_8 = 5'h0b;
  localparam int FIFO_DEPTH = 8;
  localparam int DRV_W = 4;
  // driver switch that grounds the y plane while waiting for a touch
  localparam logic [3:0] DRV_Y_MINUS = 4'h1;

  // ************************************************************
  // decoded command
  // ************************************************************
  typedef struct packed {
    logic [2:0] channel_select_field;
    logic mode_8bit;
    logic reference_mode_bit;
    logic reference_power_bit;
    logic converter_powerdown_bit;
  } tac_cmd_s;

  localparam tac_cmd_s CMD_RESET = '0;
  localparam logic REF_ON_RESET = 1'b0;
  localparam logic PEN_EN_RESET = 1'b1;

  // ************************************************************
  // analog front end controls
  // ************************************************************
  typedef struct packed {
    logic [2:0] mux_sel;
    logic ref_diff;
    logic [3:0] panel_drive;
    logic sample_en;
    logic hold_en;
    logic conv_start;
    logic adc_power_on;
    logic ref_power_on;
    logic xp_pullup_en;
  } tac_ana_s;

endpackage

`default_nettype wire

// >>> sim/tac_serial_ctrl_props.sv
// port assertions for the touch converter serial control block.
// assumes clk_en held high and serial clock halves of 4 clk_sys or more.
`default_nettype none

module tac_serial_ctrl_props #(
  parameter logic [7:0] POS_CHAN_MASK = 8'h3a
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // serial pins
  input wire logic serial_clock,
  input wire logic cs_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic busy,
  input wire logic busy_oe,
  // alert and analog side
  input wire logic touch_alert_out,
  input wire logic result_ready,
  input wire tac_pkg::tac_ana_s analog_ctrl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ************************************************************
  // serial pins
  // ************************************************************
  // six samples cover the two select sync flops that drive the enables, with margin
  chk_out_idle: assert property (cs_n [*6] |-> !serial_out_oe)
    else $error("data out driven while deselected");
  chk_out_on: assert property (!cs_n [*6] |-> serial_out_oe)
    else $error("data out not driven while selected");
  chk_busy_idle: assert property (cs_n [*6] |-> !busy_oe)
    else $error("busy driven while deselected");
  chk_busy_edge: assert property ($changed(busy) && busy_oe |->
    !serial_clock && !$past(serial_clock, 3))
    else $error("busy moved away from a falling edge");
  chk_data_edge: assert property ($changed(serial_out) &&
    serial_out_oe |-> !serial_clock && !$past(serial_clock, 3))
    else $error("data out moved away from a falling edge");

  // ************************************************************
  // conversion and power
  // ************************************************************
  chk_ref_kept: assert property (cs_n [*6] |->
    $stable(analog_ctrl.ref_power_on))
    else $error("reference changed while deselected");
  chk_power_hold: assert property (analog_ctrl.hold_en |->
    analog_ctrl.adc_power_on) else $error("converter off while converting");
  chk_start_pulse: assert property (analog_ctrl.conv_start |->
    analog_ctrl.hold_en ##1 !analog_ctrl.conv_start)
    else $error("conversion start not a single pulse in hold");
  chk_alert_pos: assert property (analog_ctrl.sample_en &&
    POS_CHAN_MASK[analog_ctrl.mux_sel] |->
    !touch_alert_out && !analog_ctrl.xp_pullup_en)
    else $error("alert or pull-up active in position sampling");
  chk_alert_aux: assert property (analog_ctrl.sample_en &&
    !POS_CHAN_MASK[analog_ctrl.mux_sel] |-> touch_alert_out)
    else $error("alert low in auxiliary sampling");
  chk_y_ground: assert property (!analog_ctrl.adc_power_on &&
    analog_ctrl.xp_pullup_en |->
    analog_ctrl.panel_drive == tac_pkg::DRV_Y_MINUS)
    else $error("y plane not grounded while waiting for touch");

  cover property ($rose(busy));
  cover property (!result_ready);
  cover property (analog_ctrl.conv_start);
endmodule

bind tac_serial_ctrl tac_serial_ctrl_props #(.POS_CHAN_MASK(POS_CHAN_MASK))
  u_props (.clk_sys(clk_sys), .reset_n(reset_n),
  .serial_clock(serial_clock), .cs_n(cs_n), .serial_out(serial_out),
  .serial_out_oe(serial_out_oe), .busy(busy), .busy_oe(busy_oe),
  .touch_alert_out(touch_alert_out), .result_ready(result_ready),
  .analog_ctrl(analog_ctrl));

`default_nettype wire

// >>> sim/tac_host_model.sv
// host model: drives serial clock, select and data, records data out and
// busy seen just before each rising serial clock edge.
// assumes the bench's clk_sys; pins change on its falling edge only.
`default_nettype none

module tac_host_model (
  // clock
  input wire logic clk_sys,
  // pins towards the block
  output logic serial_clock,
  output logic cs_n,
  output logic serial_in,
  // pins from the block
  input wire logic serial_out,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 8;
  logic [63:0] obs;
  logic [63:0] bsy;

  // clock stands low between frames; data idles high to tempt a start
  initial begin
    serial_clock = 1'b0;
    cs_n = 1'b1;
    serial_in = 1'b1;
  end

  // din bit 63 goes out on rise 1; obs[k] shows the fall before rise k
  task automatic xfer(input logic [63:0] din, input int n);
    obs = '0;
    bsy = '0;
    @(negedge clk_sys) cs_n = 1'b0;
    repeat (HALF) @(negedge clk_sys);
    for (int k = 1; k <= n; k++) begin
      serial_in = din[64-k];
      repeat (HALF) @(negedge clk_sys);
      obs[k] = serial_out;
      bsy[k] = busy;
      serial_clock = 1'b1;
      repeat (HALF) @(negedge clk_sys);
      serial_clock = 1'b0;
    end
    repeat (HALF) @(negedge clk_sys);
  endtask

  task automatic deselect();
    @(negedge clk_sys) cs_n = 1'b1;
    serial_in = 1'b1;
    repeat (HALF) @(negedge clk_sys);
  endtask
endmodule

`default_nettype wire

// >>> sim/tb_top.sv
// bench for the touch converter serial control block: a command table,
// then empty buffer, overlapped frames and abort.
// assumes tac_pkg, the block, the host model and the checker come first.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] POS = 8'h3a;
  typedef struct packed {
    logic [7:0] cmd;
    logic [11:0] data;
    logic [11:0] exp;
  } tac_row_s;
  logic clk_sys, reset_n, serial_clock, cs_n, serial_in, serial_out;
  logic serial_out_oe, busy, busy_oe, xp_sense, touch_alert_out;
  logic result_valid, result_ready;
  logic clk_en;
  logic [11:0] result_data;
  tac_pkg::tac_ana_s analog_ctrl;
  int n_fail = 0;
  int samples_checked = 0;
  // every channel, both sizes, all four power settings
  tac_row_s rows[8] = '{
    '{8'h84, 12'hf0f, 12'hf0f}, '{8'h99, 12'h5a3, 12'h05a},
    '{8'ha6, 12'h001, 12'h001}, '{8'hbb, 12'hfff, 12'h0ff},
    '{8'hc0, 12'h800, 12'h800}, '{8'hd9, 12'h7e1, 12'h07e},
    '{8'he6, 12'h3c5, 12'h3c5}, '{8'hff, 12'h0a0, 12'h00a}};

  tac_serial_ctrl #(.POS_CHAN_MASK(POS)) DUT (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .serial_clock(serial_clock),
    .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .busy(busy), .busy_oe(busy_oe),
    .xp_sense(xp_sense), .touch_alert_out(touch_alert_out),
    .result_valid(result_valid), .result_ready(result_ready),
    .result_data(result_data), .analog_ctrl(analog_ctrl));
  tac_host_model host (.clk_sys(clk_sys), .serial_clock(serial_clock),
    .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
    .busy(busy));

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] word(input int s, input int b);
    logic [11:0] w;
    w = '0;
    for (int j = 0; j < b; j++) w[b-1-j] = host.obs[s+9+j];
    return w;
  endfunction

  task automatic push(input logic [11:0] d);
    @(negedge clk_sys);
    result_data = d;
    result_valid = 1'b1;
    while (result_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    result_valid = 1'b0;
  endtask

  task automatic run_row(input tac_row_s r);
    int b;
    b = r.cmd[3] ? 8 : 12;
    host.xfer({r.cmd, 56'h0}, 24);
    check(host.bsy[9], 1'b1);
    check(host.bsy[10], 1'b0);
    check(word(1, b), r.exp);
    check(host.obs[b+10], 1'b0);
    check(analog_ctrl.mux_sel, r.cmd[6:4]);
    check(analog_ctrl.ref_diff, !r.cmd[2]);
    check(analog_ctrl.ref_power_on, r.cmd[1]);
    check(analog_ctrl.adc_power_on, r.cmd[0]);
    check(analog_ctrl.xp_pullup_en, !r.cmd[0]);
    if (!r.cmd[0]) begin
      check(analog_ctrl.panel_drive, tac_pkg::DRV_Y_MINUS);
    end
    // alert is only looked at once the command is over
    for (int x = 0; x < 2; x++) begin
      xp_sense = x[0];
      repeat (6) @(negedge clk_sys);
      check(touch_alert_out,
        r.cmd[0] ? !POS[r.cmd[6:4]] : x[0]);
    end
    host.deselect();
    check(serial_out_oe, 1'b0);
    check(busy_oe, 1'b0);
    check(analog_ctrl.ref_power_on, r.cmd[1]);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // whole run is near 50 us; three times that means a hang
  initial begin
    #150000;
    n_fail++;
    test_done();
  end

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    xp_sense = 1'b1;
    result_valid = 1'b0;
    result_data = '0;
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    check(serial_out_oe, 1'b0);
    check(analog_ctrl.ref_power_on, 1'b0);
    // enable low must freeze the x+ synchroniser with the rest
    repeat (4) @(negedge clk_sys);
    clk_en = 1'b0;
    xp_sense = 1'b0;
    repeat (6) @(negedge clk_sys);
    check(touch_alert_out, 1'b1);
    clk_en = 1'b1;
    repeat (6) @(negedge clk_sys);
    check(touch_alert_out, 1'b0);
    xp_sense = 1'b1;
    $display("test reset done");
    foreach (rows[i]) push(rows[i].data);
    check(result_ready, 1'b0);
    foreach (rows[i]) run_row(rows[i]);
    $display("test table done");
    host.xfer({8'h84, 56'h0}, 24);
    check(word(1, 12), 12'h000);
    host.deselect();
    // stray high bit on rise 12 must not start a command
    push(12'h9c3);
    push(12'h36a);
    host.xfer({8'h84, 7'h08, 8'h84, 41'h0}, 40);
    check(word(1, 12), 12'h9c3);
    check(host.bsy[20], 1'b0);
    check(word(16, 12), 12'h36a);
    host.deselect();
    push(12'hc35);
    push(12'h5aa);
    host.xfer({8'h8c, 3'h0, 8'h8c, 45'h0}, 32);
    check(word(1, 8), 12'h0c3);
    check(word(12, 8), 12'h05a);
    host.deselect();
    $display("test overlap done");
    push(12'h2d1);
    push(12'h4b7);
    host.xfer({8'h86, 56'h0}, 24);
    host.deselect();
    check(word(1, 12), 12'h2d1);
    host.xfer({8'h84, 56'h0}, 6);
    host.deselect();
    check(analog_ctrl.ref_power_on, 1'b1);
    check(analog_ctrl.hold_en, 1'b0);
    host.xfer({8'h84, 56'h0}, 24);
    check(word(1, 12), 12'h4b7);
    check(analog_ctrl.ref_power_on, 1'b0);
    host.deselect();
    // deselect in mid conversion drops hold and converter power at once
    host.xfer({8'h84, 56'h0}, 14);
    host.deselect();
    check(analog_ctrl.hold_en, 1'b0);
    check(analog_ctrl.adc_power_on, 1'b0);
    $display("test abort done");
    test_done();
  end
endmodule

`default_nettype wire
